//--- rtl/ccr_cfg.svh
// constants of the converter control register and its serial port
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
`define CCR_ADDR_STATUS     6'h00
`define CCR_ADDR_CTRL       6'h01
`define CCR_ADDR_DATA       6'h02
`define CCR_CTRL_RESET      16'h0000
`define CCR_RDY_DEL_BIT     12
`define CCR_CONT_BIT        11
`define CCR_STAT_BIT        10
`define CCR_FRAME_BIT       9
`define CCR_REF_BIT         8
`define CCR_PWR_HI          7
`define CCR_PWR_LO          6
`define CCR_MODE_HI         5
`define CCR_MODE_LO         2
`define CCR_CLK_HI          1
`define CCR_CLK_LO          0
`define CCR_CMD_WRITE_N_BIT 7
`define CCR_CMD_READ_BIT    6
`define CCR_CMD_READ_DATA   8'h42
`define CCR_ONES_RESET      64
`define CCR_EXT_DIV         4
`define CCR_SYS_CLK_MHZ     40
`define CCR_RDY_DEL_SHORT_NS 10
`define CCR_RDY_DEL_LONG_NS  100
`define CCR_RDY_DEL_SHORT_CYC ((`CCR_RDY_DEL_SHORT_NS * `CCR_SYS_CLK_MHZ + 999) / 1000)
`define CCR_RDY_DEL_LONG_CYC  ((`CCR_RDY_DEL_LONG_NS * `CCR_SYS_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/ccr_ctrl.sv
// serial port and control register of the converter
//
// Notes on behaviour
// - control register is 16 bits at address 1, msb first, resets to zero.
// - bit 12 picks 10 ns or 100 ns minimum before ready reappears.
// - with bit 11 set, data shifts out on clocks after each ready.
// - input line is sampled during continuous readout to catch that command.
// - 64 ones in a row on the input reset the device.
// - bit 10 appends the status byte after every data read.
// - bit 9 clear: pin returns to ready after the chosen delay.
// - bit 9 set: last bit is held on the pin until select rises.
// - bit 8 enables internal reference and drives it out.
// - bits 7:6 give low power for 00, mid for 01, or full power for codes 10 and 11.
// - bits 5:2 hold the four-bit operating mode.
// - bits 1:0 codes 00, 01, 10 choose internal, internal shown, external clock.
// - code 11 divides the external clock by four.
// - mode codes 0 to 5: continuous, single, standby, power-down, idle, zero cal.
// - single conversion ends in standby; ready stays low until data read.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"
module ccr_ctrl #(
  parameter int DW = 24,
  parameter int SW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          din,
  output logic               dout_rdy,
  output logic               dout_oe,
  input  wire logic [DW-1:0] conv_data,
  input  wire logic [SW-1:0] conv_status,
  input  wire logic          conv_valid,
  output logic               conv_ready,
  input  wire logic          osc_clk,
  input  wire logic          ext_clk_in,
  output logic               clk_pin_out,
  output logic               clk_pin_oe,
  output logic               mclk_tick,
  output logic               ref_enable,
  output logic               low_power,
  output logic               mid_power,
  output logic               full_power,
  output ccr_pkg::ccr_mode_t operating_mode,
  output ccr_pkg::ccr_clk_t  clock_source
);
  import ccr_pkg::*;
  localparam int TXW = DW + SW;

  ccr_state_t     state, next_state;
  logic [15:0]    ctrl, next_ctrl;
  logic [5:0]     bit_cnt, next_bit_cnt, tx_len, next_tx_len;
  logic [15:0]    rxsh, next_rxsh;
  logic [TXW-1:0] txsh, next_txsh, head;
  logic [2:0]     hold_cnt, next_hold_cnt;
  logic [6:0]     ones_cnt, next_ones_cnt;
  logic [1:0]     div_cnt, next_div_cnt;
  logic           rd_data, next_rd_data, cont_active, next_cont_active;
  logic           sclk_q, ext_q, osc_q, next_mclk, next_clk_out;
  logic           sclk_rise, sclk_fall, ext_rise, osc_rise, soft_rst;
  logic           data_avail, pop, single_done;
  logic [7:0]     cmd_byte;

  ccr_pair_buf #(.W(TXW), .DEPTH(2)) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (conv_valid),
    .in_data   ({conv_data, conv_status}),
    .in_ready  (conv_ready),
    .out_ready (pop),
    .out_valid (data_avail),
    .out_data  (head)
  );

  // word and length to shift out for a read of one address
  function automatic logic [6+TXW-1:0] tx_load(input logic [5:0] addr,
                                               input logic [TXW-1:0] hd,
                                               input logic [15:0] ctl);
    unique case (addr)
      `CCR_ADDR_DATA:
        if (ctl[`CCR_STAT_BIT]) tx_load = {6'(TXW), hd};
        else tx_load = {6'(DW), hd[TXW-1:SW], {SW{1'b0}}};
      `CCR_ADDR_CTRL:   tx_load = {6'h10, ctl, {(TXW-16){1'b0}}};
      `CCR_ADDR_STATUS: tx_load = {6'(SW), hd[SW-1:0], {DW{1'b0}}};
      default:          tx_load = {6'(SW), {TXW{1'b0}}};
    endcase
  endfunction

  assign sclk_rise   = sclk & ~sclk_q;
  assign sclk_fall   = ~sclk & sclk_q;
  assign ext_rise    = ext_clk_in & ~ext_q;
  assign osc_rise    = osc_clk & ~osc_q;
  assign cmd_byte    = {rxsh[6:0], din};
  assign soft_rst    = sclk_rise & din & (ones_cnt == 7'(`CCR_ONES_RESET - 1));
  assign single_done = conv_valid & conv_ready
                       & (ctrl[`CCR_MODE_HI:`CCR_MODE_LO] == CCR_MODE_SINGLE);
  // pin shows shifted data while a read runs, otherwise active-low ready
  assign dout_rdy    = (state == CCR_ST_RD || state == CCR_ST_HOLD) ? txsh[TXW-1] : ~data_avail;
  assign dout_oe     = ~cs_n;
  assign ref_enable  = ctrl[`CCR_REF_BIT];
  assign low_power   = (ctrl[`CCR_PWR_HI:`CCR_PWR_LO] == 2'h0);
  assign mid_power   = (ctrl[`CCR_PWR_HI:`CCR_PWR_LO] == 2'h1);
  assign full_power  = ctrl[`CCR_PWR_HI];
  assign operating_mode = ccr_mode_t'(ctrl[`CCR_MODE_HI:`CCR_MODE_LO]);
  assign clock_source   = ccr_clk_t'(ctrl[`CCR_CLK_HI:`CCR_CLK_LO]);
  assign clk_pin_oe     = (clock_source == CCR_CLK_INT_OUT);

  always_comb begin
    next_state       = state;
    next_ctrl        = ctrl;
    next_bit_cnt     = bit_cnt;
    next_tx_len      = tx_len;
    next_rxsh        = rxsh;
    next_txsh        = txsh;
    next_hold_cnt    = hold_cnt;
    next_rd_data     = rd_data;
    next_cont_active = cont_active;
    next_ones_cnt    = ones_cnt;
    pop              = 1'b0;
    if (sclk_rise) begin
      next_ones_cnt = din ? ones_cnt + 7'h01 : 7'h00;
      next_rxsh     = {rxsh[14:0], din};
    end
    unique case (state)
      CCR_ST_IDLE: begin
        if (!cs_n) begin
          if (cont_active && data_avail) begin
            if (sclk_fall) begin
              {next_tx_len, next_txsh} = tx_load(`CCR_ADDR_DATA, head, ctrl);
              next_rd_data = 1'b1;
              next_bit_cnt = 6'h00;
              next_state   = CCR_ST_RD;
            end
          end else if (sclk_rise && !cont_active) begin
            next_bit_cnt = 6'h01;
            next_state   = CCR_ST_CMD;
          end
        end
      end
      CCR_ST_CMD: begin
        if (sclk_rise) begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == 6'h07) begin
            next_bit_cnt = 6'h00;
            if (cmd_byte[`CCR_CMD_WRITE_N_BIT]) begin
              next_state = CCR_ST_IDLE;
            end else if (!cmd_byte[`CCR_CMD_READ_BIT]) begin
              next_state = (cmd_byte[5:0] == `CCR_ADDR_CTRL) ? CCR_ST_WR : CCR_ST_IDLE;
            end else begin
              {next_tx_len, next_txsh} = tx_load(cmd_byte[5:0], head, ctrl);
              next_rd_data = (cmd_byte[5:0] == `CCR_ADDR_DATA);
              if (next_rd_data && ctrl[`CCR_CONT_BIT]) begin
                next_cont_active = 1'b1;
              end
              next_state = CCR_ST_RD;
            end
          end
        end
      end
      CCR_ST_WR: begin
        if (sclk_rise) begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == 6'h0f) begin
            next_ctrl  = {rxsh[14:0], din};
            next_state = CCR_ST_IDLE;
          end
        end
      end
      CCR_ST_RD: begin
        if (sclk_rise) begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (cont_active && bit_cnt == 6'h07 && cmd_byte == `CCR_CMD_READ_DATA) begin
            next_cont_active = 1'b0;
          end
          if (bit_cnt == tx_len - 6'h01) begin
            pop           = rd_data & data_avail;
            next_hold_cnt = ctrl[`CCR_RDY_DEL_BIT] ? 3'(`CCR_RDY_DEL_LONG_CYC)
                                                   : 3'(`CCR_RDY_DEL_SHORT_CYC);
            next_state    = CCR_ST_HOLD;
          end
        end else if (sclk_fall && bit_cnt != 6'h00) begin
          next_txsh = {txsh[TXW-2:0], 1'b0};
        end
      end
      CCR_ST_HOLD: begin
        // framing holds the last bit; otherwise ready comes back after the delay
        if (!ctrl[`CCR_FRAME_BIT]) begin
          if (hold_cnt <= 3'h1) next_state = CCR_ST_IDLE;
          else next_hold_cnt = hold_cnt - 3'h1;
        end
      end
      default: next_state = CCR_ST_IDLE;
    endcase
    if (cs_n) begin
      next_state = CCR_ST_IDLE;
    end
    if (single_done) begin
      next_ctrl[`CCR_MODE_HI:`CCR_MODE_LO] = CCR_MODE_STANDBY;
    end
    if (soft_rst) begin
      next_state       = CCR_ST_IDLE;
      next_ctrl        = `CCR_CTRL_RESET;
      next_cont_active = 1'b0;
      next_ones_cnt    = 7'h00;
    end
  end

  always_comb begin
    next_div_cnt = div_cnt;
    if (clock_source == CCR_CLK_EXT_DIV && ext_rise) begin
      next_div_cnt = div_cnt + 2'h1;
    end
    unique case (clock_source)
      CCR_CLK_INT, CCR_CLK_INT_OUT: next_mclk = osc_rise;
      CCR_CLK_EXT:     next_mclk = ext_rise;
      CCR_CLK_EXT_DIV: next_mclk = ext_rise && div_cnt == 2'(`CCR_EXT_DIV - 1);
    endcase
    next_clk_out = clk_pin_oe & osc_clk;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state       <= CCR_ST_IDLE;
      ctrl        <= `CCR_CTRL_RESET;
      bit_cnt     <= 6'h00;
      tx_len      <= 6'h00;
      rxsh        <= 16'h0000;
      txsh        <= '0;
      hold_cnt    <= 3'h0;
      rd_data     <= 1'b0;
      cont_active <= 1'b0;
      ones_cnt    <= 7'h00;
      div_cnt     <= 2'h0;
      sclk_q      <= 1'b1;
      ext_q       <= 1'b0;
      osc_q       <= 1'b0;
      mclk_tick   <= 1'b0;
      clk_pin_out <= 1'b0;
    end else begin
      state       <= next_state;
      ctrl        <= next_ctrl;
      bit_cnt     <= next_bit_cnt;
      tx_len      <= next_tx_len;
      rxsh        <= next_rxsh;
      txsh        <= next_txsh;
      hold_cnt    <= next_hold_cnt;
      rd_data     <= next_rd_data;
      cont_active <= next_cont_active;
      ones_cnt    <= next_ones_cnt;
      div_cnt     <= next_div_cnt;
      sclk_q      <= sclk;
      ext_q       <= ext_clk_in;
      osc_q       <= osc_clk;
      mclk_tick   <= next_mclk;
      clk_pin_out <= next_clk_out;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence wr_last_s;
    state == CCR_ST_WR && sclk_rise && bit_cnt == 6'h0f && !cs_n && !soft_rst && !single_done;
  endsequence
  sequence hold_enter_s;
    $rose(state == CCR_ST_HOLD) && !ctrl[`CCR_FRAME_BIT] && !cs_n;
  endsequence

  reset_clear_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |=> ctrl == 16'h0000 && state == CCR_ST_IDLE) else $error("control not cleared");
  wr_commit_a: assert property (wr_last_s
    |=> ctrl[15:1] == $past(rxsh[14:0]) && ctrl[0] == $past(din))
    else $error("write not committed");
  hold_short_a: assert property (hold_enter_s and !ctrl[`CCR_RDY_DEL_BIT]
    |=> state == CCR_ST_IDLE || cs_n) else $error("short ready delay wrong");
  hold_long_a: assert property (hold_enter_s and ctrl[`CCR_RDY_DEL_BIT] && !sclk_rise
    |-> (state == CCR_ST_HOLD)[*4] ##1 state != CCR_ST_HOLD) else $error("long ready delay wrong");
  frame_hold_a: assert property (state == CCR_ST_HOLD && ctrl[`CCR_FRAME_BIT] && !cs_n
    && !soft_rst |=> state == CCR_ST_HOLD && dout_rdy == $past(dout_rdy)) else $error("lsb not held");
  cont_start_a: assert property (state == CCR_ST_IDLE && cont_active && data_avail && !cs_n
    && sclk_fall |=> state == CCR_ST_RD && rd_data) else $error("continuous read missed");
  cont_exit_a: assert property (state == CCR_ST_RD && cont_active && sclk_rise && !cs_n
    && bit_cnt == 6'h07 && cmd_byte == `CCR_CMD_READ_DATA |=> !cont_active) else $error("exit missed");
  ones_reset_a: assert property (sclk_rise && din && ones_cnt == 7'h3f
    |=> ctrl == 16'h0000 && state == CCR_ST_IDLE && !cont_active) else $error("ones reset missed");
  status_len_a: assert property ($rose(state == CCR_ST_RD) && rd_data
    |-> tx_len == (ctrl[`CCR_STAT_BIT] ? 6'h20 : 6'h18)) else $error("read length wrong");
  single_stby_a: assert property (single_done && !soft_rst
    |=> operating_mode == CCR_MODE_STANDBY) else $error("single conversion not ended");
  div_four_a: assert property (mclk_tick && clock_source == CCR_CLK_EXT_DIV
    |=> (!mclk_tick || clock_source != CCR_CLK_EXT_DIV)[*7]) else $error("divide by four wrong");
endmodule // ccr_ctrl
`default_nettype wire

//--- rtl/ccr_pair_buf.sv
// small result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ccr_pair_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2,
  localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  input  wire logic         out_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   count, next_count;
  logic          push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // ccr_pair_buf
`default_nettype wire

//--- rtl/ccr_pkg.sv
// types of the converter control register block
package ccr_pkg;
  typedef enum logic [2:0] {
    CCR_ST_IDLE = 3'h0,
    CCR_ST_CMD  = 3'h1,
    CCR_ST_WR   = 3'h3,
    CCR_ST_RD   = 3'h2,
    CCR_ST_HOLD = 3'h6
  } ccr_state_t;
  typedef enum logic [3:0] {
    CCR_MODE_CONT    = 4'h0,
    CCR_MODE_SINGLE  = 4'h1,
    CCR_MODE_STANDBY = 4'h2,
    CCR_MODE_PDOWN   = 4'h3,
    CCR_MODE_IDLE    = 4'h4,
    CCR_MODE_ZCAL    = 4'h5
  } ccr_mode_t;
  typedef enum logic [1:0] {
    CCR_CLK_INT     = 2'h0,
    CCR_CLK_INT_OUT = 2'h1,
    CCR_CLK_EXT     = 2'h2,
    CCR_CLK_EXT_DIV = 2'h3
  } ccr_clk_t;
endpackage

//--- verif/ccr_host_model.sv
// host-side serial model that drives the converter's serial port
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
  input  wire logic sys_clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout_rdy
);
  int slow = 0;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // din is set as sclk falls and cleared to zero late in the high phase; the device samples it on the rise
  task automatic bit_io(input logic b, output logic r);
    @(posedge sys_clk);
    sclk <= 1'b0;
    din  <= b;
    repeat (2 + slow) @(posedge sys_clk);
    @(negedge sys_clk);
    r = dout_rdy;
    @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (2 + slow) @(posedge sys_clk);
    din <= 1'b0;
  endtask
  task automatic sel(input logic v);
    @(posedge sys_clk);
    cs_n <= v;
    @(posedge sys_clk);
  endtask
endmodule // ccr_host_model
`default_nettype wire

//--- verif/converter_control_register_tb.sv
// self-checking bench for the converter control register block
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"
module converter_control_register_tb;
  import ccr_pkg::*;
  logic sys_clk = 1'b0, rst, osc_clk, ext_clk_in;
  logic sclk, cs_n, din, dout_rdy, dout_oe, conv_valid, conv_ready;
  logic [23:0] conv_data;
  logic [7:0]  conv_status;
  logic clk_pin_out, clk_pin_oe, mclk_tick, ref_enable, low_power, mid_power, full_power;
  ccr_mode_t operating_mode;
  ccr_clk_t  clock_source;
  int fail_count = 0, checks = 0, cyc = 0, run = 0, last_run = 0;
  int ph = 0, osc_r = 0, ext_r = 0, ticks = 0, pins = 0;
  logic [31:0] seed = 32'h00000040, q[$];
  logic [15:0] ctrl_m;
  always #12.5 sys_clk = ~sys_clk;
  ccr_ctrl u_ccr_ctrl (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy(dout_rdy), .dout_oe(dout_oe), .conv_data(conv_data), .conv_status(conv_status),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .osc_clk(osc_clk),
    .ext_clk_in(ext_clk_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .mclk_tick(mclk_tick), .ref_enable(ref_enable), .low_power(low_power),
    .mid_power(mid_power), .full_power(full_power), .operating_mode(operating_mode),
    .clock_source(clock_source));
  ccr_host_model u_host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy(dout_rdy));
  // free-running clock sources; osc period 6 cycles, ext period 4 cycles
  always @(posedge sys_clk) begin
    ph <= ph + 1;
    if (ph % 3 == 2) osc_clk <= ~osc_clk;
    if (ph % 3 == 2 && !osc_clk) osc_r <= osc_r + 1;
    if (ph % 2 == 1) ext_clk_in <= ~ext_clk_in;
    if (ph % 2 == 1 && !ext_clk_in) ext_r <= ext_r + 1;
    if (mclk_tick === 1'b1) ticks <= ticks + 1;
    if (clk_pin_out === 1'b1) pins <= pins + 1;
    if (dout_rdy === 1'b0) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic sbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) u_host.bit_io(b[i], r);
  endtask
  task automatic wr(input logic [15:0] v);
    logic r;
    u_host.sel(1'b0);
    sbyte(8'h01);
    for (int i = 15; i >= 0; i--) u_host.bit_io(v[i], r);
    u_host.sel(1'b1);
    ctrl_m = v;
  endtask
  task automatic rd(input bit cmd, input logic [7:0] c, input logic [7:0] d8, input int n,
                    output logic [31:0] v);
    logic r;
    v = 32'h00000000;
    u_host.sel(1'b0);
    if (cmd) sbyte(c);
    for (int i = 0; i < n; i++) begin
      u_host.bit_io((i < 8) ? d8[7 - i] : 1'b0, r);
      v = {v[30:0], r};
    end
  endtask
  task automatic fin();
    repeat (8) @(posedge sys_clk);
    u_host.sel(1'b1);
  endtask
  task automatic rdc();
    logic [31:0] v;
    rd(1'b1, 8'h41, 8'h00, 16, v);
    fin();
    chk("ctrl", {16'h0000, ctrl_m}, v);
  endtask
  task automatic rdd(input bit cmd, input logic [7:0] d8, input int n);
    logic [31:0] v;
    rd(cmd, `CCR_CMD_READ_DATA, d8, n, v);
    fin();
    chk("data", (n == 32) ? q[0] : {8'h00, q[0][31:8]}, v);
    void'(q.pop_front());
  endtask
  task automatic push(output bit acc);
    logic [31:0] w;
    w = rnd();
    acc = 1'b0;
    @(posedge sys_clk);
    conv_data <= w[31:8];
    conv_status <= w[7:0];
    conv_valid <= 1'b1;
    for (int i = 0; i < 4 && !acc; i++) begin
      @(negedge sys_clk);
      acc = conv_ready;
      @(posedge sys_clk);
    end
    conv_valid <= 1'b0;
    if (acc) q.push_back(w);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    logic [15:0] v;
    bit a;
    int ls, t0, r0, s, p0;
    rst <= 1'b1;
    osc_clk <= 1'b0;
    ext_clk_in <= 1'b0;
    conv_valid <= 1'b0;
    conv_data <= 24'h000000;
    conv_status <= 8'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    ctrl_m = 16'h0000;
    repeat (2) @(posedge sys_clk);
    chk("low_power", 1, low_power);
    rdc();
    // every power, clock and mode code; reserved bits kept zero
    for (int i = 0; i < 6; i++) begin
      u_host.slow = i % 2;
      v = (rnd() & 32'h1500) | ((i % 4) << 6) | (i << 2) | (i % 4);
      wr(v);
      chk("ref", v[8], ref_enable);
      chk("pwr", {v[7:6] == 2'b00, v[7:6] == 2'b01, v[7]},
          {low_power, mid_power, full_power});
      chk("mode", v[5:2], operating_mode);
      chk("clk", {v[1:0], v[1:0] == 2'b01}, {clock_source, clk_pin_oe});
      rdc();
    end
    u_host.slow = 0;
    wr(16'h0008);
    rdc();
    ls = last_run;
    wr(16'h1008);
    rdc();
    chk("ready delay", 3, last_run - ls);
    wr(16'h0208);
    rd(1'b1, 8'h41, 8'h00, 16, r0);
    repeat (20) @(posedge sys_clk);
    chk("lsb held", 0, dout_rdy);
    chk("framed ctrl", 32'h00000208, r0);
    chk("oe on", 1, dout_oe);
    u_host.sel(1'b1);
    chk("oe", 0, dout_oe);
    wr(16'h0408);
    push(a);
    push(a);
    push(a);
    chk("refused", 0, a);
    chk("full", 0, conv_ready);
    rd(1'b1, 8'h40, 8'h00, 8, r0);
    fin();
    chk("status", {24'h000000, q[0][7:0]}, r0);
    rdd(1'b1, 8'h00, 32);
    rdd(1'b1, 8'h00, 32);
    chk("empty", 1, dout_rdy);
    wr(16'h0808);
    push(a);
    rdd(1'b1, 8'h00, 24);
    push(a);
    rdd(1'b0, 8'h00, 24);
    push(a);
    rdd(1'b0, `CCR_CMD_READ_DATA, 24);
    wr(16'h0008);
    rdc();
    wr(16'h0004);
    push(a);
    repeat (3) @(posedge sys_clk);
    chk("single", CCR_MODE_STANDBY, operating_mode);
    chk("ready low", 0, dout_rdy);
    ctrl_m[5:2] = 4'h2;
    rdd(1'b1, 8'h00, 24);
    for (s = 0; s < 4; s++) begin
      wr(16'h0008 | s);
      repeat (8) @(posedge sys_clk);
      t0 = ticks;
      p0 = pins;
      r0 = (s < 2) ? osc_r : ext_r;
      repeat (200) @(posedge sys_clk);
      p0 = pins - p0;
      chk("clk pin", 1, (s == 1) ? (p0 >= 96 && p0 <= 104) : (p0 == 0));
      r0 = ((s < 2) ? osc_r : ext_r) - r0;
      t0 = (ticks - t0) * ((s == 3) ? 4 : 1);
      chk("ticks", 1, (t0 >= r0 - 4) && (t0 <= r0 + 4));
    end
    wr(16'h0108);
    u_host.sel(1'b0);
    for (int i = 0; i < 64; i++) u_host.bit_io(1'b1, a);
    u_host.sel(1'b1);
    chk("soft reset", 0, ref_enable);
    ctrl_m = 16'h0000;
    rdc();
    end_sim();
  end
endmodule // converter_control_register_tb
`default_nettype wire
